// >>> design/reset_and_watchdog_control.sv
// Purpose: reset combiner, start-up delay counter and watchdog timer
// Assumes: one pclk domain; watchdog oscillator arrives as a pin level
// Notes:   APB slave, zero wait states, no interrupt logic beyond wd_irq
//
// Overview of operation
// [RULE1] reset loads initial values, then fetch vector
// [RULE2] pins reset asynchronously on any source; here only power-on and the enabled pin assert without a clock
// [RULE3] delay counter stretches reset after release
// [RULE4] four causes: power-on, pin, watchdog, brown-out
// [RULE5] power-on asserts at once, releases after delay
// [RULE6] long low pin resets without clock
// [RULE7] pin-disable fuse ignores reset pin
// [RULE8] brown-out asserts, releases after delay counter
// [RULE9] short brown-out dips are filtered out
// [RULE10] watchdog reset pulse one clock wide
// [RULE11] counter advances on 128 kHz oscillator
// [RULE12] restart instruction clears watchdog counter
// [RULE13] interrupt mode raises wake-capable request
// [RULE14] reset mode resets on every expiry
// [RULE15] combined mode: interrupt first, then reset
// [RULE16] always-on fuse forces reset mode
// [RULE17] firmware unlocks by writing change and enable
// [RULE18] disable or prescale only inside window
// [RULE19] timeout range about 16 ms to 8 s
// [RULE20] firmware clears cause flag and enable early
// [RULE21] cause flag forces reset enable high
// [RULE22] prescaler code doubles from 2048 cycles
// [RULE23] change enable self-clears after four cycles
// [RULE24] vectoring or writing one clears flag
// [RULE25] sources ORed, async assert, sync release
// [RULE26] oscillator synchronised before raising events
//
// Our own choices: the APB slave port and the register offsets.
`default_nettype none
module reset_and_watchdog_control #(
  parameter int WD_BASE   = rw_pkg::WD_BASE_DEF,
  parameter int TOUT_BASE = rw_pkg::TOUT_BASE_DEF
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // reset sources and configuration
  input  wire logic        por_ok,
  input  wire logic        reset_pin_n,
  input  wire logic        brownout_low,
  input  wire rw_pkg::fuses_t fuses,
  input  wire logic        wd_osc,
  // core side
  input  wire logic        wd_restart,
  input  wire logic        wd_vector_taken,
  output logic             sys_reset_n,
  output logic             reset_vector_fetch,
  output logic             wd_reset_pulse,
  output logic             wd_irq,
  output logic             wd_wake
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (WD_BASE < 1 || (WD_BASE << 9) >= (1 << rw_pkg::WD_W)) begin : g_chk_wd
    $error("WD_BASE out of range");
  end
  if (TOUT_BASE < 1 || (TOUT_BASE << 4) >= (1 << rw_pkg::DLY_W)) begin : g_chk_dly
    $error("TOUT_BASE out of range");
  end
  if (rw_pkg::BOD_CYC >= (1 << rw_pkg::BOD_W)) begin : g_chk_bod
    $error("BOD_CYC too wide");
  end

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // reserved codes clamp to the longest period rather than a short one
  function automatic logic [rw_pkg::WD_W-1:0] wd_limit(input logic [3:0] code);
    logic [3:0] c;
    c = (code > rw_pkg::WD_MAX_CODE) ? rw_pkg::WD_MAX_CODE : code;
    wd_limit = rw_pkg::WD_W'(WD_BASE) << c; // [RULE22] [RULE19]
  endfunction

  // crystal selections get one extra doubling for oscillator settling
  function automatic logic [rw_pkg::DLY_W-1:0] dly_limit(input rw_pkg::fuses_t f);
    logic [2:0] sh;
    sh = {1'b0, f.startup_time_select} + {2'b00, f.clock_source_select[3]};
    dly_limit = rw_pkg::DLY_W'(TOUT_BASE) << sh; // [RULE3]
  endfunction

  function automatic logic is_reg(input logic [11:0] a);
    is_reg = (a == rw_pkg::OFF_CAUSE) || (a == rw_pkg::OFF_WDCTRL);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rw_pkg::state_t s_q;
  rw_pkg::state_t s_d;

  logic       async_src;
  logic       src;
  logic       osc_tick;
  logic       eff_re;
  logic       eff_ie;
  logic       wd_run;
  logic       expire;
  logic       wr;
  logic [7:0] wv;
  logic [7:0] ctl_rd;
  logic [3:0] raw_in;

  // sources seen without any clock: power-on and the enabled pin
  assign async_src = ~por_ok | (~reset_pin_n & ~fuses.reset_pin_disable_fuse); // [RULE25] [RULE7]
  assign raw_in    = {wd_osc, brownout_low, reset_pin_n, por_ok};
  assign eff_re    = s_q.reset_enable_bit | s_q.cause[rw_pkg::CAU_WD] | fuses.always_on_fuse; // [RULE21]
  assign eff_ie    = s_q.timeout_irq_enable & ~fuses.always_on_fuse; // [RULE16]
  assign ctl_rd    = {s_q.timeout_flag, eff_ie, s_q.timeout_prescaler[3], s_q.change_enable_bit, eff_re, s_q.timeout_prescaler[2:0]};
  assign wr        = psel & penable & pwrite;
  assign wv        = pwdata[7:0];

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~is_reg(paddr);
  assign prdata  = s_q.prdata;
  // async assert, release only from the clocked phase machine
  assign sys_reset_n = (s_q.phase == rw_pkg::PH_RUN) & ~s_q.wd_pulse & ~async_src; // [RULE2] [RULE25]
  assign reset_vector_fetch = s_q.fetch; // [RULE1]
  assign wd_reset_pulse     = s_q.wd_pulse;
  assign wd_irq             = s_q.timeout_flag & eff_ie; // [RULE13]
  assign wd_wake            = s_q.timeout_flag & eff_ie; // [RULE13]

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // three-stage synchronisers; a change counts once stages two and three agree
    s_d.sy0 = raw_in;
    s_d.sy1 = s_q.sy0;
    s_d.sy2 = s_q.sy1;
    for (int i = 0; i < 4; i++) begin
      if (s_q.sy1[i] == s_q.sy2[i]) begin
        s_d.flt[i] = s_q.sy2[i];
      end
    end
    s_d.osc_prev = s_q.flt[rw_pkg::SY_OSC];
    osc_tick = s_q.flt[rw_pkg::SY_OSC] & ~s_q.osc_prev; // [RULE26] [RULE11]

    // brown-out must persist before it counts
    if (fuses.brownout_enable && s_q.flt[rw_pkg::SY_BOD]) begin
      if (s_q.bod_cnt >= rw_pkg::BOD_W'(rw_pkg::BOD_CYC - 1)) begin
        s_d.bod_valid = 1'b1; // [RULE9] [RULE8]
      end else begin
        s_d.bod_cnt = s_q.bod_cnt + 1'b1;
      end
    end else begin
      s_d.bod_cnt   = '0;
      s_d.bod_valid = 1'b0;
    end

    src = ~s_q.flt[rw_pkg::SY_POR]
        | (~s_q.flt[rw_pkg::SY_EXT] & ~fuses.reset_pin_disable_fuse)
        | s_q.bod_valid | s_q.wd_pulse; // [RULE4] [RULE7] [RULE25]

    // change window countdown
    if (s_q.ce_cnt != 3'h0) begin
      s_d.ce_cnt = s_q.ce_cnt - 1'b1;
      if (s_q.ce_cnt == 3'h1) begin
        s_d.change_enable_bit = 1'b0; // [RULE23]
      end
    end

    // register writes
    if (wr && paddr == rw_pkg::OFF_CAUSE) begin
      s_d.cause = s_q.cause & pwdata[3:0];
    end
    if (wr && paddr == rw_pkg::OFF_WDCTRL) begin
      if (wv[rw_pkg::CTL_FLAG]) begin
        s_d.timeout_flag = 1'b0; // [RULE24]
      end
      s_d.timeout_irq_enable = wv[rw_pkg::CTL_IE];
      if (s_q.ce_cnt != 3'h0 && !wv[rw_pkg::CTL_CE]) begin
        s_d.reset_enable_bit    = wv[rw_pkg::CTL_RE]; // [RULE18]
        s_d.timeout_prescaler    = {wv[rw_pkg::CTL_P3], wv[2:0]}; // [RULE18]
        s_d.ce_cnt = 3'h0;
        s_d.change_enable_bit   = 1'b0;
      end else if (wv[rw_pkg::CTL_RE]) begin
        s_d.reset_enable_bit = 1'b1;
      end
      if (wv[rw_pkg::CTL_CE] && wv[rw_pkg::CTL_RE]) begin
        s_d.change_enable_bit   = 1'b1; // [RULE17]
        s_d.ce_cnt = 3'(rw_pkg::CE_WINDOW_CYC); // [RULE23]
      end
    end

    // interrupt vectoring
    if (wd_vector_taken) begin
      s_d.timeout_flag = 1'b0; // [RULE24]
      if (eff_re) begin
        s_d.timeout_irq_enable = 1'b0; // [RULE24] [RULE15]
      end
    end

    // watchdog counter
    wd_run = eff_re | eff_ie;
    expire = 1'b0;
    s_d.wd_pulse = 1'b0; // [RULE10]
    if (wd_restart || !wd_run) begin
      s_d.wd_cnt = '0; // [RULE12]
    end else if (osc_tick) begin
      if (s_q.wd_cnt + 1'b1 >= wd_limit(s_q.timeout_prescaler)) begin
        s_d.wd_cnt = '0;
        expire     = 1'b1; // [RULE11]
      end else begin
        s_d.wd_cnt = s_q.wd_cnt + 1'b1;
      end
    end
    if (expire && s_q.phase == rw_pkg::PH_RUN) begin
      if (eff_ie && !(eff_re && s_q.timeout_flag)) begin
        s_d.timeout_flag = 1'b1; // [RULE13] [RULE15]
      end else if (eff_re) begin
        s_d.wd_pulse = 1'b1; // [RULE14] [RULE10]
        s_d.cause[rw_pkg::CAU_WD] = 1'b1;
      end
    end

    // cause flags; sets win over software clears
    if (~s_q.flt[rw_pkg::SY_EXT] && !fuses.reset_pin_disable_fuse) begin
      s_d.cause[rw_pkg::CAU_EXT] = 1'b1; // [RULE6]
    end
    if (s_q.bod_valid) begin
      s_d.cause[rw_pkg::CAU_BO] = 1'b1; // [RULE8]
    end
    if (~s_q.flt[rw_pkg::SY_POR]) begin
      s_d.cause = rw_pkg::CAUSE_RST; // [RULE5]
    end

    // reset phase machine
    s_d.fetch = 1'b0;
    case (s_q.phase)
      rw_pkg::PH_HOLD: begin
        s_d.dly_cnt = '0;
        if (!src) begin
          s_d.phase = rw_pkg::PH_STRETCH; // [RULE10]
        end
      end
      rw_pkg::PH_STRETCH: begin
        if (src) begin
          s_d.phase   = rw_pkg::PH_HOLD;
          s_d.dly_cnt = '0;
        end else if (s_q.dly_cnt >= dly_limit(fuses) - 1'b1) begin
          s_d.phase = rw_pkg::PH_RUN; // [RULE3] [RULE5] [RULE6] [RULE8]
          s_d.fetch = 1'b1; // [RULE1]
        end else begin
          s_d.dly_cnt = s_q.dly_cnt + 1'b1;
        end
      end
      rw_pkg::PH_RUN: begin
        if (src) begin
          s_d.phase = rw_pkg::PH_HOLD;
        end
      end
      default: begin
        s_d.phase = rw_pkg::PH_HOLD;
      end
    endcase

    // while held in reset the control fields return to initial values
    if (s_q.phase != rw_pkg::PH_RUN || async_src) begin
      s_d.timeout_flag   = 1'b0; // [RULE1]
      s_d.timeout_irq_enable   = 1'b0;
      s_d.change_enable_bit   = 1'b0;
      s_d.reset_enable_bit    = 1'b0;
      s_d.timeout_prescaler    = 4'h0;
      s_d.ce_cnt = 3'h0;
      s_d.wd_cnt = '0;
    end
    if (fuses.always_on_fuse || s_d.cause[rw_pkg::CAU_WD]) begin
      s_d.reset_enable_bit = 1'b1; // [RULE16] [RULE21]
    end
    if (fuses.always_on_fuse) begin
      s_d.timeout_irq_enable = 1'b0; // [RULE16]
    end

    // read data captured in the setup phase
    if (psel && !penable && !pwrite) begin
      case (paddr)
        rw_pkg::OFF_CAUSE:  s_d.prdata = {28'h0000000, s_q.cause};
        rw_pkg::OFF_WDCTRL: s_d.prdata = {24'h000000, ctl_rd};
        default:            s_d.prdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q           <= '0;
      s_q.sy0       <= rw_pkg::SY_RST;
      s_q.sy1       <= rw_pkg::SY_RST;
      s_q.sy2       <= rw_pkg::SY_RST;
      s_q.flt       <= rw_pkg::SY_RST;
      s_q.phase     <= rw_pkg::PH_HOLD;
      s_q.cause     <= rw_pkg::CAUSE_RST;
    end else begin
      s_q <= s_d;
    end
  end

endmodule
`default_nettype wire

// >>> design/rw_pkg.sv
// Purpose: shared constants and types of the reset and watchdog controller
// Assumes: 25 MHz pclk, 32-bit APB, byte offsets as printed
// Notes:   only the brown-out filter count derives from a named time below
`default_nettype none
package rw_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 25_000_000;
  localparam int WD_OSC_HZ     = 128_000;
  localparam int T_BOD_NS      = 2000;
  localparam int BOD_CYC       = (T_BOD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CE_WINDOW_CYC = 4;
  localparam int WD_BASE_DEF   = 2048;
  localparam int TOUT_BASE_DEF = 64;
  localparam logic [3:0] WD_MAX_CODE = 4'h9;
  localparam int DLY_W = 16;
  localparam int BOD_W = 8;
  localparam int WD_W  = 21;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CAUSE  = 12'h054;
  localparam logic [11:0] OFF_WDCTRL = 12'h060;
  localparam int CTL_FLAG = 7;
  localparam int CTL_IE   = 6;
  localparam int CTL_P3   = 5;
  localparam int CTL_CE   = 4;
  localparam int CTL_RE   = 3;
  localparam int CAU_WD   = 3;
  localparam int CAU_BO   = 2;
  localparam int CAU_EXT  = 1;
  localparam int CAU_POR  = 0;
  localparam logic [3:0] CAUSE_RST = 4'h1;
  // synchroniser lanes and their idle values after reset
  localparam int SY_POR = 0;
  localparam int SY_EXT = 1;
  localparam int SY_BOD = 2;
  localparam int SY_OSC = 3;
  localparam logic [3:0] SY_RST = 4'h2;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       reset_pin_disable_fuse;
    logic       always_on_fuse;
    logic       brownout_enable;
    logic [2:0] brownout_level_fuse;
    logic [1:0] startup_time_select;
    logic [3:0] clock_source_select;
  } fuses_t;
  typedef enum logic [1:0] {PH_HOLD, PH_STRETCH, PH_RUN} phase_t;
  typedef struct packed {
    logic [3:0]       sy0;
    logic [3:0]       sy1;
    logic [3:0]       sy2;
    logic [3:0]       flt;
    logic             osc_prev;
    logic [WD_W-1:0]  wd_cnt;
    logic [BOD_W-1:0] bod_cnt;
    logic             bod_valid;
    logic [DLY_W-1:0] dly_cnt;
    phase_t           phase;
    logic             fetch;
    logic             wd_pulse;
    logic [2:0]       ce_cnt;
    logic             timeout_flag;
    logic             timeout_irq_enable;
    logic             change_enable_bit;
    logic             reset_enable_bit;
    logic [3:0]       timeout_prescaler;
    logic [3:0]       cause;
    logic [31:0]      prdata;
  } state_t;
endpackage
`default_nettype wire

// >>> tb/reset_and_watchdog_control_bench.sv
// Purpose: self-checking bench for the reset and watchdog controller
// Assumes: WD_BASE 4, TOUT_BASE 2, watchdog oscillator period 300 ns
// Notes:   expected values are worked out here, never read back
`default_nettype none
`define CHK(n, x, s) begin check_count++; if ((s) !== (x)) begin errors++; \
  $display("[FAIL] %s exp %0h got %0h", n, x, s); end end
module reset_and_watchdog_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r, rnd = 32'h75fd;
  logic pready, pslverr, por_ok = 0, reset_pin_n = 1, brownout_low = 0, wd_osc = 0;
  logic wd_restart, wd_vector_taken, sys_reset_n, reset_vector_fetch;
  logic wd_reset_pulse, wd_irq, wd_wake, kick_en = 0, take_en = 0;
  rw_pkg::fuses_t fuses = '0;
  int errors = 0, check_count = 0, c, dly;
  localparam logic [11:0] CA = rw_pkg::OFF_CAUSE;
  localparam logic [11:0] WC = rw_pkg::OFF_WDCTRL;
  always #20 pclk = ~pclk;
  // oscillator phase deliberately unrelated to pclk; the 5 ns offset keeps
  // its edges off both pclk edges so the first sync stage never races it
  initial begin
    #5;
    forever #150 wd_osc = ~wd_osc;
  end
  reset_and_watchdog_control #(.WD_BASE(4), .TOUT_BASE(2)) dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .por_ok, .reset_pin_n,
    .brownout_low, .fuses, .wd_osc, .wd_restart, .wd_vector_taken, .sys_reset_n,
    .reset_vector_fetch, .wd_reset_pulse, .wd_irq, .wd_wake);
  rw_core_model core (.pclk, .kick_en, .take_en, .wd_irq, .wd_restart, .wd_vector_taken);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] x);
    apb(0, a, '0);
    `CHK(n, x, r)
    `CHK({n, "_err"}, a != CA && a != WC, e)
  endtask
  // 0: reset released, 1: irq, 2: reset pulse
  task automatic wt(input int s);
    c = 0;
    while (c < 3000 && !(s == 0 ? sys_reset_n === 1'b1 : s == 1 ? wd_irq === 1'b1
                         : wd_reset_pulse === 1'b1)) begin
      @(posedge pclk);
      c++;
    end
    if (c >= 3000) begin
      errors++;
      $display("[FAIL] wait_%0d exp event got timeout", s);
    end
    if (s == 0 && c < 3000) begin
      `CHK("fetch", 1'b1, reset_vector_fetch)
    end
  endtask
  task automatic tend(input string n);
    $display("test %s done", n);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    errors++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    repeat (4) @(posedge pclk);
    `CHK("por_hold", 1'b0, sys_reset_n)
    por_ok <= 1;
    wt(0);
    `CHK("por_delay", 1'b1, c > 2 && c < 13)
    rd("cause_por", CA, 32'h1);
    rd("ctrl_init", WC, 32'h0);
    rd("unmapped", 12'h100, 32'h0);
    tend("power_on");
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      dly = 2 << (int'(rnd[1:0]) + int'(rnd[5]));
      fuses.startup_time_select <= rnd[1:0];
      fuses.clock_source_select <= rnd[5:2];
      reset_pin_n <= 0;
      @(posedge pclk);
      `CHK("pin_async", 1'b0, sys_reset_n)
      repeat (8) @(posedge pclk);
      reset_pin_n <= 1;
      wt(0);
      `CHK("pin_delay", 1'b1, c >= dly && c <= dly + 8)
    end
    rd("cause_ext", CA, 32'h3);
    apb(1, CA, '0);
    fuses.reset_pin_disable_fuse <= 1;
    @(posedge pclk);
    reset_pin_n <= 0;
    repeat (20) @(posedge pclk);
    `CHK("pin_off", 1'b1, sys_reset_n)
    reset_pin_n <= 1;
    fuses.brownout_enable <= 1;
    brownout_low <= 1;
    repeat (20) @(posedge pclk);
    brownout_low <= 0;
    repeat (10) @(posedge pclk);
    `CHK("dip", 1'b1, sys_reset_n)
    brownout_low <= 1;
    repeat (70) @(posedge pclk);
    `CHK("brownout", 1'b0, sys_reset_n)
    brownout_low <= 0;
    wt(0);
    rd("cause_bo", CA, 32'h4);
    apb(1, CA, '0);
    tend("pin_brownout");
    for (int p = 0; p < 3; p++) begin
      take_en <= 1;
      apb(1, WC, 32'h58);
      apb(1, WC, 32'h40 | p);
      wt(1);
      `CHK("wake", 1'b1, wd_wake)
      repeat (3) @(posedge pclk);
      `CHK("vector", 1'b0, wd_irq)
      wt(1);
      `CHK("period", 1'b1, 2 * c >= 60 * (1 << p) - 14 && 2 * c <= 60 * (1 << p) + 4)
    end
    take_en <= 0;
    kick_en <= 1;
    repeat (300) @(posedge pclk);
    `CHK("kicked", 1'b0, wd_irq)
    tend("interrupt");
    apb(1, WC, 32'h58);
    apb(1, WC, 32'h48);
    kick_en <= 0;
    wt(1);
    `CHK("first_irq", 1'b1, sys_reset_n)
    wt(2);
    `CHK("second_rst", 1'b1, wd_reset_pulse)
    kick_en <= 1;
    wt(0);
    rd("cause_wd", CA, 32'h8);
    rd("forced_re", WC, 32'h8);
    apb(1, WC, '0);
    rd("still_re", WC, 32'h8);
    apb(1, CA, '0);
    // the flag set the enable bit itself; only the timed sequence clears it
    rd("re_free", WC, 32'h8);
    apb(1, WC, 32'h08);
    rd("re_set", WC, 32'h8);
    apb(1, WC, 32'h18);
    repeat (6) @(posedge pclk);
    apb(1, WC, 32'h01);
    rd("shut", WC, 32'h8);
    apb(1, WC, 32'h18);
    apb(1, WC, 32'h00);
    rd("re_clear", WC, 32'h0);
    tend("timed");
    presetn <= 0;
    fuses.always_on_fuse <= 1;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    wt(0);
    apb(1, WC, 32'h40);
    rd("fuse_mode", WC, 32'h8);
    tend("always_on");
    stop_test();
  end
endmodule
`default_nettype wire

// >>> tb/rw_core_model.sv
// Purpose: core-side partner that kicks the watchdog and takes its vector
// Assumes: kick every 16 pclk cycles while enabled
// Notes:   vectors only when told to, like firmware with interrupts off
`default_nettype none
module rw_core_model (
  input  wire logic pclk,
  input  wire logic kick_en,
  input  wire logic take_en,
  input  wire logic wd_irq,
  output var  logic wd_restart,
  output var  logic wd_vector_taken
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] n = 4'h0;
  initial wd_restart = 1'b0;
  initial wd_vector_taken = 1'b0;
  always @(posedge pclk) begin
    n <= n + 4'h1;
    wd_restart <= kick_en && n == 4'h0;
    wd_vector_taken <= take_en && wd_irq && !wd_vector_taken;
  end
endmodule
`default_nettype wire

// >>> tb/rw_properties.sv
// Purpose: port checks on the reset and watchdog controller
// Assumes: one pclk domain; presetn low disables every check
// Notes:   async reset paths are only seen at the sampling edge
`default_nettype none
module rw_properties #(
  parameter int WD_BASE   = 2048,
  parameter int TOUT_BASE = 64
) (
  // apb
  input wire logic           pclk, presetn, psel, penable, pwrite,
  input wire logic [11:0]    paddr,
  input wire logic [31:0]    pwdata, prdata,
  input wire logic           pready, pslverr,
  // sources and fuses
  input wire logic           por_ok, reset_pin_n, brownout_low, wd_osc,
  input wire rw_pkg::fuses_t fuses,
  // core side
  input wire logic           wd_restart, wd_vector_taken, sys_reset_n,
  input wire logic           reset_vector_fetch, wd_reset_pulse, wd_irq, wd_wake
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_por_async:
    assert property (!por_ok |-> !sys_reset_n) else $error("supply low, no reset");
  chk_pin_async:
    assert property (!reset_pin_n && !fuses.reset_pin_disable_fuse |-> !sys_reset_n)
      else $error("pin low, no reset");
  chk_pulse_width:
    assert property (wd_reset_pulse |=> !wd_reset_pulse) else $error("pulse too wide");
  chk_pulse_resets:
    assert property (wd_reset_pulse |-> !sys_reset_n) else $error("pulse without reset");
  chk_stretch_after:
    assert property (wd_reset_pulse |=> !sys_reset_n [*2]) else $error("no stretch");
  chk_fetch_release:
    assert property ($rose(sys_reset_n) |-> reset_vector_fetch ##1 !reset_vector_fetch)
      else $error("fetch pulse wrong");
  chk_irq_wake:
    assert property (wd_irq |-> wd_wake) else $error("irq cannot wake");
  chk_vector_clear:
    assert property (wd_vector_taken && wd_irq |=> !wd_irq) else $error("flag kept");
  chk_fuse_no_irq:
    assert property (fuses.always_on_fuse |-> !wd_irq) else $error("irq under fuse");
endmodule
bind reset_and_watchdog_control rw_properties #(.WD_BASE(WD_BASE), .TOUT_BASE(TOUT_BASE))
  u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .por_ok, .reset_pin_n, .brownout_low, .wd_osc, .fuses, .wd_restart,
  .wd_vector_taken, .sys_reset_n, .reset_vector_fetch, .wd_reset_pulse, .wd_irq, .wd_wake);
`default_nettype wire
